// >>> core/ccp_pkg.sv
// shared constants and types for the six-channel capture/compare block
package ccp_pkg;
    localparam int CHANNELS = 6;

    // channel mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic level_sel;   // output_level_select
        logic cmp_en;      // comparator_enable
        logic rise_en;     // rise_capture_enable
        logic fall_en;     // fall_capture_enable
        logic match_en;    // match_irq_enable
        logic invert_sel;  // output_invert_select
        logic pwm_en;      // pulse width bit
        logic irq_en;      // module_irq_enable
    } mode_t;

    // register port request bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    // main counter bundle from the counter array
    typedef struct packed {
        logic [7:0] count_high;
        logic [7:0] count_low;
        logic       overflow;   // one-cycle pulse at main counter overflow
    } counter_t;

    // register offsets
    localparam logic [7:0] VALUE_LOW_ADDR  [CHANNELS] =
        '{8'hd2, 8'hd4, 8'hd6, 8'he2, 8'he4, 8'he6};
    localparam logic [7:0] VALUE_HIGH_ADDR [CHANNELS] =
        '{8'hd3, 8'hd5, 8'hd7, 8'he3, 8'he5, 8'he7};
    localparam logic [7:0] MODE_ADDR       [CHANNELS] =
        '{8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7};
    localparam logic [7:0] FLAGS_ADDR      = 8'he1;

    // reset values and low byte wrap limits
    localparam logic [7:0] VALUE_RESET = 8'h00;
    localparam mode_t      MODE_RESET  = '0;
    localparam logic [7:0] READ_NONE   = 8'h00;
    localparam logic [7:0] LOW_TOP     = 8'hff;
    localparam logic [7:0] LOW_BOTTOM  = 8'h00;
endpackage

// >>> core/ccp_channels.sv
// six capture, compare and pulse width channels on the shared main counter
`timescale 1ns/1ps
// Function
// R01 - compare match with match enable sets flag
// R02 - six channels, each gated by irq enable
// R03 - pin edge captures counter into value registers
// R04 - both edge enables capture both edges
// R05 - compare mode: enable on, no capture edges
// R06 - compare value reloads at counter overflow
// R07 - compare match drives pin regardless of match enable
// R08 - level/invert selects: hold, toggle, low, high
// R09 - low write clears, high write sets comparator
// R10 - software writes low byte before high
// R11 - high write ignored when mode bits zero
// R12 - comparator off behaves as no operation; the code still captures when an edge enable is set
// R13 - 8-bit pwm: low while count_low not above
// R14 - 8-bit pwm value reloads at low wrap
// R15 - 8-bit pwm: enable and pwm, no edges
// R16 - invert select forces pwm pin high
// R17 - 8-bit pwm equality flags with irq enable
// R18 - 16-bit pwm compares full counter, invert forces high
// R19 - 16-bit pwm selection and equality interrupt
// R20 - windowed pwm high between low and high values
// R21 - software keeps high value above low value
// R22 - invert select inverts windowed waveform
// R23 - windowed interrupt at low without match, at high with match
// R24 - module flags sticky until software clears
// R25 - windowed mode: comparator, both edge enables and pwm set
// R26 - everything resets to zero, no operation
module ccp_channels (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  ccp_pkg::bus_req_t                     bus,
    output logic     [7:0]                        rdata,
    input  ccp_pkg::counter_t                     counter,
    input  wire logic [ccp_pkg::CHANNELS-1:0]     channel_pin_in,
    output logic     [ccp_pkg::CHANNELS-1:0]      channel_pin_out,
    output logic     [ccp_pkg::CHANNELS-1:0]      channel_pin_oe,
    output logic     [ccp_pkg::CHANNELS-1:0]      module_flag,
    output logic                                  irq
);
    import ccp_pkg::*;

    // shared counter views and change detection
    logic [15:0] count_q;
    wire  [15:0] count       = {counter.count_high, counter.count_low};
    wire         count_new   = (count != count_q);
    wire         low_new     = (counter.count_low != count_q[7:0]);
    wire         low_wrap    = (count_q[7:0] == LOW_TOP) && (counter.count_low == LOW_BOTTOM)
                               && low_new;
    wire         flags_wr    = bus.wr && (bus.addr == FLAGS_ADDR);

    // previous counter value for edge and wrap detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count;
        end
    end

    // per-channel read data and flag set events
    logic [7:0]          ch_rdata [CHANNELS];
    logic [CHANNELS-1:0] irq_term;
    logic [CHANNELS-1:0] flag_set;

    genvar n;
    generate
        for (n = 0; n < CHANNELS; n++) begin : g_ch
            mode_t      mode;
            logic [7:0] value_low;
            logic [7:0] value_high;
            logic [7:0] work_low;
            logic [7:0] work_high;
            logic [1:0] pin_sync;
            logic       pin_q;

            // register decode for this channel
            wire low_sel  = (bus.addr == VALUE_LOW_ADDR[n]);
            wire high_sel = (bus.addr == VALUE_HIGH_ADDR[n]);
            wire mode_sel = (bus.addr == MODE_ADDR[n]);
            wire low_wr   = bus.wr && low_sel;
            wire high_wr  = bus.wr && high_sel;
            wire mode_wr  = bus.wr && mode_sel;
            // all bits but the comparator and module irq enables clear: no operation
            wire others_zero = ({mode.level_sel, mode.rise_en, mode.fall_en, mode.match_en,
                                 mode.invert_sel, mode.pwm_en} == 6'h00);

            // mode decode; comparator off leaves only capture, otherwise no operation
            wire edge_any  = mode.rise_en || mode.fall_en;
            wire is_cap    = edge_any && !(mode.cmp_en && mode.pwm_en);
            wire is_cmp    = mode.cmp_en && !edge_any && !mode.pwm_en;            // R05 R12
            wire is_pwm8   = mode.cmp_en && mode.pwm_en && !edge_any;             // R15
            wire is_pwm16  = mode.cmp_en && mode.pwm_en && mode.rise_en
                             && !mode.fall_en;                                    // R19
            wire is_windowed_pulse_mode   = mode.cmp_en && mode.pwm_en && mode.rise_en
                             && mode.fall_en;                                     // R25

            // synchronised pin edges
            wire pin_s     = pin_sync[1];
            wire rise      = pin_s && !pin_q;
            wire fall      = !pin_s && pin_q;
            wire capture   = is_cap && ((mode.rise_en && rise)
                             || (mode.fall_en && fall));                         // R03 R04

            // comparisons against working copies
            wire [15:0] work16  = {work_high, work_low};
            wire eq16      = count_new && (count == work16);
            wire eq_low    = low_new && (counter.count_low == work_low);
            wire eq_high   = low_new && (counter.count_low == work_high);
            wire above_low = (counter.count_low > work_low);
            wire above_hi  = (counter.count_low > work_high);
            wire above16   = (count > work16);

            // reload points of the double buffers
            wire load16    = counter.overflow && (is_cmp || is_pwm16);            // R06
            wire load8     = low_wrap && (is_pwm8 || is_windowed_pulse_mode);                    // R14 R20

            // flag events for each mode
            wire cmp_match = is_cmp && eq16;
            assign flag_set[n] = capture                                          // R03
                || (cmp_match && mode.match_en)                                   // R01
                || (is_pwm8 && eq_low && mode.irq_en)                             // R17
                || (is_pwm16 && eq16 && mode.irq_en)                              // R19
                || (is_windowed_pulse_mode && mode.irq_en
                    && ((eq_low && !mode.match_en)
                        || (eq_high && mode.match_en)));                          // R23

            // next pin level for the active mode
            logic next_pin;
            always_comb begin
                next_pin = channel_pin_out[n];
                if (cmp_match) begin
                    case ({mode.level_sel, mode.invert_sel})                      // R07 R08
                        2'b01:   next_pin = !channel_pin_out[n];
                        2'b10:   next_pin = 1'b0;
                        2'b11:   next_pin = 1'b1;
                        default: next_pin = channel_pin_out[n];
                    endcase
                end else if (is_pwm8) begin
                    next_pin = mode.invert_sel || above_low;                      // R13 R16
                end else if (is_pwm16) begin
                    next_pin = mode.invert_sel || above16;                        // R18
                end else if (is_windowed_pulse_mode) begin
                    next_pin = (above_low && !above_hi) ^ mode.invert_sel;        // R20 R22
                end
            end

            // pin synchroniser and edge history
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pin_sync <= 2'b00;
                    pin_q    <= 1'b0;
                end else begin
                    pin_sync <= {pin_sync[0], channel_pin_in[n]};
                    pin_q    <= pin_s;
                end
            end

            // mode register with comparator enable side effects
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode <= MODE_RESET;                                           // R26
                end else if (mode_wr) begin
                    mode <= mode_t'(bus.wdata);
                end else if (low_wr) begin
                    mode.cmp_en <= 1'b0;                                          // R09
                end else if (high_wr && !others_zero) begin
                    mode.cmp_en <= 1'b1;                                          // R09 R11
                end
            end

            // value registers; a capture beats a software write
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    value_low  <= VALUE_RESET;
                    value_high <= VALUE_RESET;
                end else if (capture) begin
                    value_low  <= counter.count_low;                              // R03
                    value_high <= counter.count_high;
                end else begin
                    if (low_wr) begin
                        value_low <= bus.wdata;
                    end
                    if (high_wr) begin
                        value_high <= bus.wdata;
                    end
                end
            end

            // working compare copies
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    work_low  <= VALUE_RESET;                                     // R26
                    work_high <= VALUE_RESET;
                end else if (load16 || load8) begin
                    work_low  <= value_low;                                       // R06 R14
                    work_high <= value_high;
                end
            end

            // pin output and drive enable
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    channel_pin_out[n] <= 1'b0;
                    channel_pin_oe[n]  <= 1'b0;
                end else begin
                    channel_pin_out[n] <= next_pin;
                    channel_pin_oe[n]  <= is_cmp || is_pwm8 || is_pwm16 || is_windowed_pulse_mode;
                end
            end

            // sticky flag; a set in the clearing cycle wins
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    module_flag[n] <= 1'b0;
                end else if (flag_set[n]) begin
                    module_flag[n] <= 1'b1;                                       // R24
                end else if (flags_wr && !bus.wdata[n]) begin
                    module_flag[n] <= 1'b0;                                       // R24
                end
            end

            // read mux for this channel
            assign ch_rdata[n] = low_sel  ? value_low  :
                                 high_sel ? value_high :
                                 mode_sel ? 8'(mode)   : READ_NONE;

            // interrupt contribution gated by the channel enable
            assign irq_term[n] = module_flag[n] && mode.irq_en;                   // R02
        end
    endgenerate

    // combined read data, unmapped reads return zero
    logic [7:0] next_rdata;
    logic       next_irq;
    always_comb begin
        next_rdata = READ_NONE;
        next_irq   = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            next_rdata = next_rdata | ch_rdata[i];
        end
        if (bus.addr == FLAGS_ADDR) begin
            next_rdata = {2'b00, module_flag};
        end
        next_irq = |irq_term;                                                     // R02
    end

    // registered read data and interrupt request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= READ_NONE;
            irq   <= 1'b0;
        end else begin
            rdata <= bus.rd ? next_rdata : READ_NONE;
            irq   <= next_irq;
        end
    end
endmodule

// >>> dv/ccp_channels_assertions.sv
// port checker for the capture, compare and pulse width channels
`timescale 1ns/1ps
module ccp_channels_assertions (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  ccp_pkg::bus_req_t                 bus,
    input  wire logic [7:0]                   rdata,
    input  ccp_pkg::counter_t                 counter,
    input  wire logic [ccp_pkg::CHANNELS-1:0] channel_pin_in,
    input  wire logic [ccp_pkg::CHANNELS-1:0] channel_pin_out,
    input  wire logic [ccp_pkg::CHANNELS-1:0] channel_pin_oe,
    input  wire logic [ccp_pkg::CHANNELS-1:0] module_flag,
    input  wire logic                         irq
);
    import ccp_pkg::*;
    mode_t      m0;
    logic [5:0] keep;
    // decoded channel 0 modes from the shadow
    wire cmp0  = m0.cmp_en & ~m0.rise_en & ~m0.fall_en & ~m0.pwm_en;
    wire hold0 = cmp0 & ~m0.level_sel & ~m0.invert_sel;
    wire inv0  = m0.cmp_en & m0.pwm_en & m0.invert_sel & ~m0.fall_en;
    // shadow of channel 0 mode, with the hardware comparator enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m0 <= MODE_RESET;
        end else if (bus.wr && bus.addr == MODE_ADDR[0]) begin
            m0 <= bus.wdata;
        end else if (bus.wr && bus.addr == VALUE_LOW_ADDR[0]) begin
            m0.cmp_en <= 1'b0;
        end else if (bus.wr && bus.addr == VALUE_HIGH_ADDR[0] && (m0 & 8'hbe) != 0) begin
            m0.cmp_en <= 1'b1;
        end
    end
    // flags allowed to drop are those written with zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) keep <= '0;
        else keep <= (bus.wr && bus.addr == FLAGS_ADDR) ? bus.wdata[5:0] : 6'h3f;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // flag, interrupt and pin relations
    a_flag_sticky: assert property ((($past(module_flag) & keep) & ~module_flag) == 6'h00)
        else $error("flag dropped without a clear");
    a_irq_has_flag: assert property (irq |-> $past(module_flag) != 6'h00)
        else $error("irq with no flag");
    a_irq_follows: assert property (module_flag[0] && m0.irq_en |-> ##1 irq)
        else $error("enabled flag gave no irq");
    a_reset_quiet: assert property ($fell(rst) |-> {module_flag, channel_pin_oe, irq} == '0)
        else $error("outputs not quiet after reset");
    a_off_no_drive: assert property ($past(!m0.cmp_en) |-> !channel_pin_oe[0])
        else $error("pin driven with comparator off");
    a_compare_drives: assert property ($past(cmp0) |-> channel_pin_oe[0])
        else $error("compare mode not driving");
    a_pwm8_high: assert property ($past(inv0 && !m0.rise_en) |-> channel_pin_out[0])
        else $error("forced pwm pin not high");
    a_pwm16_high: assert property ($past(inv0) && $past(m0.rise_en) |-> channel_pin_out[0])
        else $error("forced wide pwm pin not high");
    a_hold_pin: assert property ($past(hold0) && $past(hold0, 2) |-> $stable(channel_pin_out[0]))
        else $error("pin moved in hold mode");
    c_flag: cover property ($rose(|module_flag));
    c_irq: cover property ($rose(irq));
    c_forced: cover property ($past(inv0) && channel_pin_out[0]);
endmodule

bind ccp_channels ccp_channels_assertions chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .counter(counter), .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .module_flag(module_flag), .irq(irq));

// >>> dv/pin_source.sv
// far side of the channel pins: a signal source, overridden where a channel drives
`timescale 1ns/1ps
module pin_source (
    input  wire logic [ccp_pkg::CHANNELS-1:0] level,
    input  wire logic [ccp_pkg::CHANNELS-1:0] pin_out,
    input  wire logic [ccp_pkg::CHANNELS-1:0] pin_oe,
    output logic      [ccp_pkg::CHANNELS-1:0] pin
);
    import ccp_pkg::*;
    // a driving channel wins the shared line
    assign pin = (pin_oe & pin_out) | (~pin_oe & level);
endmodule

// >>> dv/counter_array_ccp_modules_test.sv
// self-checking bench for the capture, compare and pulse width channels
`timescale 1ns/1ps
module counter_array_ccp_modules_test;
    import ccp_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    bus_req_t    bus = '0;
    counter_t    counter = '0;
    logic [5:0]  src = '0;
    logic [7:0]  rdata, d, w;
    logic [5:0]  pin_in, pin_out, pin_oe, module_flag;
    logic        irq;
    logic [15:0] v, c;
    int          err_count = 0;
    int          comparisons = 0;
    int          n;
    // clock and design under test with its pin partner
    initial forever #12.5 clk = ~clk;
    ccp_channels dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .counter(counter),
        .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .module_flag(module_flag), .irq(irq));
    pin_source far (.level(src), .pin_out(pin_out), .pin_oe(pin_oe), .pin(pin_in));
    // expectation helpers
    function automatic logic cmp_pin(input logic lvl, inv, old);
        return lvl ? inv : (inv ? ~old : old);
    endfunction
    function automatic logic pwm_pin(input logic [7:0] cl, val);
        return cl > val;
    endfunction
    // compare, bus and counter tasks
    task automatic check(input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, x);
        @(posedge clk);
        bus <= '{a, x, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cnt(input logic [15:0] val);
        @(posedge clk);
        counter <= '{val[15:8], val[7:0], val == 16'h0000};
        @(posedge clk);
        counter.overflow <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // bound on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        void'($urandom(32'hc049));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            rd(VALUE_LOW_ADDR[i]);
            check(d, VALUE_RESET);
            rd(VALUE_HIGH_ADDR[i]);
            check(d, VALUE_RESET);
            rd(MODE_ADDR[i]);
            check(d, MODE_RESET);
        end
        rd(8'hc0);
        check(d, READ_NONE);
        n = $urandom_range(5);
        wr(VALUE_HIGH_ADDR[n], 8'h5a);
        rd(MODE_ADDR[n]);
        check(d, 8'h00);
        wr(MODE_ADDR[n], 8'h02);
        wr(VALUE_HIGH_ADDR[n], 8'h5a);
        rd(MODE_ADDR[n]);
        check(d, 8'h42);
        wr(VALUE_LOW_ADDR[n], 8'ha5);
        rd(MODE_ADDR[n]);
        check(d, 8'h02);
        wr(MODE_ADDR[n], 8'h00);
        // capture on both edges of a random channel
        n = $urandom_range(5);
        wr(MODE_ADDR[n], 8'h31);
        for (int e = 0; e < 2; e++) begin
            c = 16'($urandom);
            cnt(c);
            check(module_flag[n], e[0]);
            @(posedge clk);
            src[n] <= ~src[n];
            repeat (6) @(posedge clk);
            rd(VALUE_LOW_ADDR[n]);
            v[7:0] = d;
            rd(VALUE_HIGH_ADDR[n]);
            v[15:8] = d;
            check(v, c);
            check(module_flag[n], 1'b1);
            check(irq, 1'b1);
        end
        rd(FLAGS_ADDR);
        check(d, 8'(8'h01 << n));
        wr(FLAGS_ADDR, 8'(~(8'h01 << n)));
        repeat (2) @(posedge clk);
        #1 check({module_flag, irq}, 7'h00);
        wr(MODE_ADDR[n], 8'h00);
        // 8-bit and 16-bit pulse width on channel 0, boundaries, reload and invert
        v = 16'($urandom_range(254, 1));
        wr(MODE_ADDR[0], 8'h43);
        wr(VALUE_LOW_ADDR[0], v[7:0]);
        wr(VALUE_HIGH_ADDR[0], 8'h00);
        cnt(16'h12ff);
        cnt(16'h1300);
        for (int k = -1; k < 2; k++) begin
            cnt({8'h13, 8'(v[7:0] + k)});
            check(pin_out[0], pwm_pin(8'(v[7:0] + k), v[7:0]));
        end
        check(module_flag[0], 1'b1);
        w = v[7:0] ^ 8'h80;
        wr(VALUE_LOW_ADDR[0], w);
        wr(VALUE_HIGH_ADDR[0], 8'h00);
        cnt({8'h13, w});
        check(pin_out[0], pwm_pin(w, v[7:0]));
        cnt(16'h13ff);
        cnt(16'h1400);
        cnt({8'h14, w});
        check(pin_out[0], 1'b0);
        wr(MODE_ADDR[0], 8'h46);
        cnt(16'h1480);
        check(pin_out[0], 1'b1);
        wr(MODE_ADDR[0], 8'h66);
        cnt(16'h1490);
        check(pin_out[0], 1'b1);
        wr(FLAGS_ADDR, 8'h00);
        wr(MODE_ADDR[0], 8'h63);
        cnt({8'h00, w});
        check(pin_out[0], 1'b0);
        check(module_flag[0], 1'b1);
        cnt({8'h00, w} + 16'h0001);
        check(pin_out[0], 1'b1);
        // 16-bit compare with every pin action
        for (int j = 0; j < 4; j++) begin
            v = 16'($urandom_range(16'hfff0, 16'h0010));
            wr(MODE_ADDR[0], {j[1], 4'b1001, j[0], 2'b01});
            wr(VALUE_LOW_ADDR[0], v[7:0]);
            wr(VALUE_HIGH_ADDR[0], v[15:8]);
            wr(FLAGS_ADDR, 8'h00);
            cnt(v);
            check(module_flag[0], 1'b0);
            cnt(16'hffff);
            cnt(16'h0000);
            cnt(v - 16'h0001);
            d[0] = pin_out[0];
            cnt(v);
            check(pin_out[0], cmp_pin(j[1], j[0], d[0]));
            check(module_flag[0], 1'b1);
        end
        // windowed pulse width on channel 0, window edges, invert and interrupts
        wr(VALUE_LOW_ADDR[0], 8'h40);
        wr(VALUE_HIGH_ADDR[0], 8'hc0);
        wr(MODE_ADDR[0], 8'h73);
        cnt(16'h20ff);
        cnt(16'h2100);
        wr(FLAGS_ADDR, 8'h00);
        cnt(16'h2140);
        check(pin_out[0], 1'b0);
        check(module_flag[0], 1'b1);
        wr(FLAGS_ADDR, 8'h00);
        cnt(16'h2141);
        check(pin_out[0], 1'b1);
        check(pin_oe[0], 1'b1);
        cnt(16'h21c0);
        check(module_flag[0], 1'b0);
        cnt(16'h21c1);
        check(pin_out[0], 1'b0);
        wr(MODE_ADDR[0], 8'h77);
        cnt(16'h2180);
        check(pin_out[0], 1'b0);
        cnt(16'h21d0);
        check(pin_out[0], 1'b1);
        wr(MODE_ADDR[0], 8'h7b);
        wr(FLAGS_ADDR, 8'h00);
        cnt(16'h22c0);
        check(module_flag[0], 1'b1);
        wrap_up();
    end
endmodule
